/* File: kbms_pkg.sv */
// kbms_pkg: port addresses, control word codes and reset values of the key scan block
// assumes a cpu i/o bus with 8-bit port addresses and 8-bit data
package kbms_pkg;
    localparam int KBMS_ROWS = 12;
    localparam int KBMS_COLS = 8;
    localparam logic [7:0] KBMS_ADDR_STROBE_PORT = 8'hE8;
    localparam logic [7:0] KBMS_ADDR_INPUT_DATA = 8'hEA;
    localparam logic [7:0] KBMS_ADDR_INPUT_CTRL = 8'hEB;
    localparam int KBMS_GATE_POS = 4;
    localparam int KBMS_ICW_ENABLE_POS = 7;
    localparam int KBMS_ICW_AND_POS = 6;
    localparam int KBMS_ICW_HIGH_POS = 5;
    localparam int KBMS_ICW_MASK_NEXT_POS = 4;
    localparam logic [3:0] KBMS_CW_MODE_SELECT = 4'hF;
    localparam logic [3:0] KBMS_CW_INT_CONTROL = 4'h7;
    localparam logic [3:0] KBMS_CW_INT_ENABLE = 4'h3;
    localparam logic [1:0] KBMS_MODE_BIT_CONTROL = 2'h3;
    localparam logic [1:0] KBMS_MODE_RESET = 2'h1;
    localparam logic [7:0] KBMS_STROBE_PORT_RESET = 8'h00;
    localparam logic [7:0] KBMS_DIR_RESET = 8'hFF;
    localparam logic [7:0] KBMS_MASK_RESET = 8'hFF;
    localparam logic [7:0] KBMS_VECTOR_RESET = 8'h00;
    localparam logic [7:0] KBMS_UNMAPPED_READ = 8'hFF;
    typedef enum logic [1:0] {
        KBMS_CTL_IDLE = 2'b00,
        KBMS_CTL_DIR = 2'b01,
        KBMS_CTL_MASK = 2'b10
    } kbms_ctl_type;
endpackage : kbms_pkg

/* File: kbms_row_demux.sv */
// kbms_row_demux: gated row code to one-hot keyboard row strobes
// assumes row code and gate come from a register on the same clock
`timescale 1ns/1ps
module kbms_row_demux
    import kbms_pkg::*;
#(
    parameter int ROWS = KBMS_ROWS
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] row_code,
    input wire logic gate,
    output logic [ROWS-1:0] row_strobe
);
    logic [ROWS-1:0] next_row_strobe;

    always_comb
    begin
        next_row_strobe = '0;
        for (int r = 0; r < ROWS; r++)
        begin
            if (gate && (row_code == 4'(r)))
            begin
                next_row_strobe[r] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            row_strobe <= '0;
        end
        else
        begin
            row_strobe <= next_row_strobe;
        end
    end

    property p_gate_closed;
        @(posedge core_clk) disable iff (!nrst)
        !gate |=> (row_strobe == '0);
    endproperty
    a_gate_closed: assert property (p_gate_closed)
        else $error("strobes not forced low with gate closed");

    property p_row_select;
        @(posedge core_clk) disable iff (!nrst)
        (gate && row_code < 4'(ROWS)) |=> ($onehot(row_strobe) && row_strobe[$past(row_code)]);
    endproperty
    a_row_select: assert property (p_row_select)
        else $error("selected row strobe missing");
endmodule : kbms_row_demux

/* File: kbms_scan.sv */
// kbms_scan: keyboard strobe port, column input port in bit control mode, key interrupt
// assumes a same-clock cpu i/o bus with one-cycle rd/wr strobes; key switches arrive async
`timescale 1ns/1ps
module kbms_scan
    import kbms_pkg::*;
#(
    parameter int ROWS = KBMS_ROWS,
    parameter int COLS = KBMS_COLS
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [ROWS*COLS-1:0] key_switch,
    output logic [ROWS-1:0] row_strobe,
    output logic [7:0] strobe_port_out,
    output logic int_req_n,
    input wire logic int_ack,
    input wire logic return_from_interrupt_instr_seen,
    output logic [7:0] int_vector
);
    logic [7:0] strobe_port;
    logic [ROWS*COLS-1:0] key_meta;
    logic [ROWS*COLS-1:0] key_sync;
    logic [COLS-1:0] column_input_bits;
    kbms_ctl_type ctl_state;
    logic [1:0] port_mode;
    logic [7:0] dir_word;
    logic [7:0] mask_word;
    logic [7:0] vector_byte;
    logic int_enable;
    logic match_all;
    logic match_high;
    logic cond;
    logic cond_q;
    logic pending;
    logic in_service;
    logic [COLS-1:0] watched;
    logic [COLS-1:0] active_bits;
    logic event_hit;
    logic ctl_wr;

    assign ctl_wr = io_wr && (io_addr == KBMS_ADDR_INPUT_CTRL);
    assign strobe_port_out = strobe_port;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strobe_port <= KBMS_STROBE_PORT_RESET;
        end
        else if (io_wr && (io_addr == KBMS_ADDR_STROBE_PORT))
        begin
            strobe_port <= io_wdata;
        end
    end

    kbms_row_demux #(
        .ROWS(ROWS)
    ) u_demux (
        .core_clk(core_clk),
        .nrst(nrst),
        .row_code(strobe_port[3:0]),
        .gate(strobe_port[KBMS_GATE_POS]),
        .row_strobe(row_strobe)
    );

    // switch contacts are asynchronous
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_meta <= '0;
            key_sync <= '0;
        end
        else
        begin
            key_meta <= key_switch;
            key_sync <= key_meta;
        end
    end

    always_comb
    begin
        column_input_bits = '1;
        for (int r = 0; r < ROWS; r++)
        begin
            // pressed key pulls low when its row is driven
            // row r bit c is key r*COLS+c
            column_input_bits = column_input_bits & ~(key_sync[r*COLS +: COLS] & {COLS{row_strobe[r]}});
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            io_rdata <= KBMS_UNMAPPED_READ;
        end
        else if (io_rd)
        begin
            case (io_addr)
                KBMS_ADDR_STROBE_PORT: io_rdata <= strobe_port;
                KBMS_ADDR_INPUT_DATA: io_rdata <= column_input_bits;
                default: io_rdata <= KBMS_UNMAPPED_READ;
            endcase
        end
    end

    // control port sequencer; the word after a mode 3 word or an interrupt word with bit 4 set is taken as direction or mask, not decoded
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl_state <= KBMS_CTL_IDLE;
            port_mode <= KBMS_MODE_RESET;
            dir_word <= KBMS_DIR_RESET;
            mask_word <= KBMS_MASK_RESET;
            vector_byte <= KBMS_VECTOR_RESET;
            int_enable <= 1'b0;
            match_all <= 1'b0;
            match_high <= 1'b0;
        end
        else if (ctl_wr)
        begin
            case (ctl_state)
                KBMS_CTL_DIR:
                begin
                    dir_word <= io_wdata;
                    ctl_state <= KBMS_CTL_IDLE;
                end
                KBMS_CTL_MASK:
                begin
                    mask_word <= io_wdata;
                    ctl_state <= KBMS_CTL_IDLE;
                end
                KBMS_CTL_IDLE:
                begin
                    if (!io_wdata[0])
                    begin
                        vector_byte <= io_wdata;
                    end
                    else if (io_wdata[3:0] == KBMS_CW_MODE_SELECT)
                    begin
                        port_mode <= io_wdata[7:6];
                        if (io_wdata[7:6] == KBMS_MODE_BIT_CONTROL)
                        begin
                            ctl_state <= KBMS_CTL_DIR;
                        end
                    end
                    else if (io_wdata[3:0] == KBMS_CW_INT_CONTROL)
                    begin
                        int_enable <= io_wdata[KBMS_ICW_ENABLE_POS];
                        match_all <= io_wdata[KBMS_ICW_AND_POS];
                        match_high <= io_wdata[KBMS_ICW_HIGH_POS];
                        if (io_wdata[KBMS_ICW_MASK_NEXT_POS])
                        begin
                            ctl_state <= KBMS_CTL_MASK;
                        end
                    end
                    else if (io_wdata[3:0] == KBMS_CW_INT_ENABLE)
                    begin
                        int_enable <= io_wdata[KBMS_ICW_ENABLE_POS];
                    end
                end
                default: ctl_state <= KBMS_CTL_IDLE;
            endcase
        end
    end

    always_comb
    begin
        watched = dir_word & ~mask_word;
        active_bits = (match_high ? column_input_bits : ~column_input_bits) & watched;
        if (match_all)
        begin
            cond = (watched != '0) && (active_bits == watched);
        end
        else
        begin
            cond = (active_bits != '0);
        end
    end

    // no handshake, fires on condition onset in bit mode only
    assign event_hit = cond && !cond_q && int_enable && (port_mode == KBMS_MODE_BIT_CONTROL);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cond_q <= 1'b0;
        end
        else
        begin
            cond_q <= cond;
        end
    end

    // new event beats an acknowledge in the same cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pending <= 1'b0;
        end
        else if (event_hit)
        begin
            pending <= 1'b1;
        end
        else if (int_ack && !in_service)
        begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            in_service <= 1'b0;
            int_vector <= KBMS_VECTOR_RESET;
        end
        else if (int_ack && pending && !in_service)
        begin
            in_service <= 1'b1;
            int_vector <= vector_byte;
        end
        else if (return_from_interrupt_instr_seen)
        begin
            in_service <= 1'b0;
        end
    end

    // request held off while one is in service
    assign int_req_n = !(pending && !in_service);

    sequence s_mode3_word;
        ctl_wr && (ctl_state == KBMS_CTL_IDLE) && (io_wdata == 8'hCF);
    endsequence
    // bus may leave idle cycles between the two control bytes
    sequence s_dir_word;
        ctl_wr && (ctl_state == KBMS_CTL_DIR) && (io_wdata == 8'hFF);
    endsequence
    property p_mode3_then_dir;
        @(posedge core_clk) disable iff (!nrst)
        s_mode3_word ##[1:4] s_dir_word |=> (port_mode == KBMS_MODE_BIT_CONTROL)
            && (dir_word == 8'hFF) && (ctl_state == KBMS_CTL_IDLE);
    endproperty
    a_mode3_then_dir: assert property (p_mode3_then_dir)
        else $error("mode 3 and direction word not taken");

    sequence s_icw_word;
        ctl_wr && (ctl_state == KBMS_CTL_IDLE) && (io_wdata == 8'h97);
    endsequence
    sequence s_mask_word;
        ctl_wr && (ctl_state == KBMS_CTL_MASK) && (io_wdata == 8'h7F);
    endsequence
    property p_icw_mask;
        @(posedge core_clk) disable iff (!nrst)
        s_icw_word |=> int_enable && (ctl_state == KBMS_CTL_MASK);
    endproperty
    a_icw_mask: assert property (p_icw_mask)
        else $error("interrupt word not applied");
    property p_mask_watch;
        @(posedge core_clk) disable iff (!nrst)
        s_icw_word ##[1:4] s_mask_word |=> (watched == (dir_word & 8'h80));
    endproperty
    a_mask_watch: assert property (p_mask_watch)
        else $error("mask word not applied");

    property p_vector_load;
        @(posedge core_clk) disable iff (!nrst)
        (ctl_wr && ctl_state == KBMS_CTL_IDLE && io_wdata == 8'h70) |=> (vector_byte == 8'h70);
    endproperty
    a_vector_load: assert property (p_vector_load)
        else $error("vector byte not loaded");

    property p_irq_source;
        @(posedge core_clk) disable iff (!nrst)
        $fell(int_req_n) |-> $past(port_mode) == KBMS_MODE_BIT_CONTROL && $past(int_enable);
    endproperty
    a_irq_source: assert property (p_irq_source)
        else $error("interrupt outside bit control mode");

    property p_ack_vector;
        @(posedge core_clk) disable iff (!nrst)
        (int_ack && !int_req_n) |=> (int_vector == $past(vector_byte)) && int_req_n;
    endproperty
    a_ack_vector: assert property (p_ack_vector)
        else $error("vector not supplied on acknowledge");

    property p_return_from_interrupt_instr_clear;
        @(posedge core_clk) disable iff (!nrst)
        (return_from_interrupt_instr_seen && !(int_ack && pending && !in_service)) |=> !in_service;
    endproperty
    a_return_from_interrupt_instr_clear: assert property (p_return_from_interrupt_instr_clear)
        else $error("service not ended by return");

    property p_port_b_read;
        @(posedge core_clk) disable iff (!nrst)
        (io_rd && io_addr == KBMS_ADDR_INPUT_DATA) |=> (io_rdata == $past(column_input_bits));
    endproperty
    a_port_b_read: assert property (p_port_b_read)
        else $error("input port read wrong");

    property p_break_key;
        @(posedge core_clk) disable iff (!nrst)
        (row_strobe == 12'h008 && key_sync[31:24] == 8'h80 && io_rd
            && io_addr == KBMS_ADDR_INPUT_DATA) |=> (io_rdata == 8'h7F);
    endproperty
    a_break_key: assert property (p_break_key)
        else $error("break key does not read 7FH");

    property p_idle_rows;
        @(posedge core_clk) disable iff (!nrst)
        (!strobe_port[KBMS_GATE_POS]) ##2 (io_rd && io_addr == KBMS_ADDR_INPUT_DATA
            && row_strobe == '0) |=> (io_rdata == 8'hFF);
    endproperty
    a_idle_rows: assert property (p_idle_rows)
        else $error("columns low with no row driven");

    property p_strobe_readback;
        @(posedge core_clk) disable iff (!nrst)
        (io_wr && io_addr == KBMS_ADDR_STROBE_PORT) ##2 (io_rd && io_addr == KBMS_ADDR_STROBE_PORT)
            |=> (io_rdata == $past(io_wdata, 3));
    endproperty
    a_strobe_readback: assert property (p_strobe_readback)
        else $error("strobe port readback wrong");
endmodule : kbms_scan

/* File: kbms_key_matrix.sv */
// kbms_key_matrix: behavioural keyboard switch matrix on the far side of the scan block
// assumes the scan block does the row gating; this model only holds switch levels
`timescale 1ns/1ps
module kbms_key_matrix
    import kbms_pkg::*;
(
    output logic [KBMS_ROWS*KBMS_COLS-1:0] key_switch
);
    // all keys released at power up
    initial
    begin
        key_switch = '0;
    end

    // key is row code times KBMS_COLS plus column bit
    task automatic press(input int row, input int col);
        key_switch[row*KBMS_COLS+col] <= 1'b1;
    endtask : press

    task automatic release_key(input int row, input int col);
        key_switch[row*KBMS_COLS+col] <= 1'b0;
    endtask : release_key
endmodule : kbms_key_matrix

/* File: kbms_scan_test.sv */
// kbms_scan_test: self-checking bench for the key scan block
// assumes the bench drives the cpu i/o bus and the key matrix model holds switch levels
`timescale 1ns/1ps
module kbms_scan_test;
    import kbms_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic [KBMS_ROWS*KBMS_COLS-1:0] key_switch;
    logic [KBMS_ROWS-1:0] row_strobe;
    logic [7:0] strobe_port_out;
    logic int_req_n;
    logic int_ack = 1'b0;
    logic return_from_interrupt_instr_seen = 1'b0;
    logic [7:0] int_vector;
    logic [7:0] rd_val;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    kbms_scan kbms_scan_i (
        .core_clk(core_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .key_switch(key_switch),
        .row_strobe(row_strobe), .strobe_port_out(strobe_port_out), .int_req_n(int_req_n),
        .int_ack(int_ack), .return_from_interrupt_instr_seen(return_from_interrupt_instr_seen), .int_vector(int_vector)
    );

    kbms_key_matrix kbms_key_matrix_i (
        .key_switch(key_switch)
    );

    always #12.5 core_clk = ~core_clk;

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // hang guard, well above the roughly 160 cycles the run needs
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle write strobe, released after the taking edge
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
    endtask : io_write

    // read data is registered on the taking edge
    task automatic io_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
    endtask : io_read

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cycles

    task automatic pulse(input int which);
        @(posedge core_clk);
        if (which == 0) int_ack <= 1'b1;
        else return_from_interrupt_instr_seen <= 1'b1;
        @(posedge core_clk);
        int_ack <= 1'b0;
        return_from_interrupt_instr_seen <= 1'b0;
        #1;
    endtask : pulse

    initial
    begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        check(row_strobe, 12'h000);
        check(int_req_n, 12'h001);
        check(io_rdata, 12'h0FF);
        // strobe one row at a time with the gate open
        for (int r = 0; r < KBMS_ROWS; r++)
        begin
            io_write(KBMS_ADDR_STROBE_PORT, 8'h10 | 8'(r));
            wait_cycles(1);
            check(row_strobe, 12'h001 << r);
        end
        // gate closed with upper bits set, then the software sequence
        io_write(KBMS_ADDR_STROBE_PORT, 8'hE5);
        wait_cycles(1);
        check(row_strobe, 12'h000);
        io_read(KBMS_ADDR_STROBE_PORT, rd_val);
        check(rd_val, 12'h0E5);
        io_write(KBMS_ADDR_STROBE_PORT, (rd_val & 8'hE0) | 8'h13);
        io_read(KBMS_ADDR_STROBE_PORT, rd_val);
        check(rd_val, 12'h0F3);
        check(strobe_port_out, 12'h0F3);
        check(row_strobe, 12'h008);
        io_read(KBMS_ADDR_INPUT_CTRL, rd_val);
        check(rd_val, 12'h0FF);
        io_read(8'h00, rd_val);
        check(rd_val, 12'h0FF);
        // column data follows only the strobed row
        @(posedge core_clk);
        kbms_key_matrix_i.press(3, 7);
        kbms_key_matrix_i.press(6, 3);
        wait_cycles(4);
        io_read(KBMS_ADDR_INPUT_DATA, rd_val);
        check(rd_val, 12'h07F);
        check(int_req_n, 12'h001);
        io_write(KBMS_ADDR_STROBE_PORT, 8'h16);
        wait_cycles(3);
        io_read(KBMS_ADDR_INPUT_DATA, rd_val);
        check(rd_val, 12'h0F7);
        io_write(KBMS_ADDR_STROBE_PORT, 8'h14);
        wait_cycles(3);
        io_read(KBMS_ADDR_INPUT_DATA, rd_val);
        check(rd_val, 12'h0FF);
        io_write(KBMS_ADDR_STROBE_PORT, 8'h03);
        wait_cycles(3);
        io_read(KBMS_ADDR_INPUT_DATA, rd_val);
        check(rd_val, 12'h0FF);
        @(posedge core_clk);
        kbms_key_matrix_i.release_key(3, 7);
        kbms_key_matrix_i.release_key(6, 3);
        // interrupt setup: vector, mode 3, direction, control, mask
        io_write(KBMS_ADDR_INPUT_CTRL, 8'h70);
        io_write(KBMS_ADDR_INPUT_CTRL, 8'hCF);
        io_write(KBMS_ADDR_INPUT_CTRL, 8'hFF);
        io_write(KBMS_ADDR_INPUT_CTRL, 8'h97);
        io_write(KBMS_ADDR_INPUT_CTRL, 8'h7F);
        io_write(KBMS_ADDR_STROBE_PORT, 8'h13);
        // masked bit of the same row must not interrupt
        @(posedge core_clk);
        kbms_key_matrix_i.press(3, 0);
        wait_cycles(6);
        check(int_req_n, 12'h001);
        @(posedge core_clk);
        kbms_key_matrix_i.press(3, 7);
        wait_cycles(4);
        check(int_req_n, 12'h000);
        pulse(0);
        check(int_req_n, 12'h001);
        check(int_vector, 12'h070);
        pulse(1);
        // edge triggered: holding the key gives no new request
        wait_cycles(3);
        check(int_req_n, 12'h001);
        @(posedge core_clk);
        kbms_key_matrix_i.release_key(3, 7);
        wait_cycles(4);
        @(posedge core_clk);
        kbms_key_matrix_i.press(3, 7);
        wait_cycles(4);
        check(int_req_n, 12'h000);
        pulse(0);
        check(int_vector, 12'h070);
        pulse(1);
        // enable-only word 03H turns the request off
        io_write(KBMS_ADDR_INPUT_CTRL, 8'h03);
        @(posedge core_clk);
        kbms_key_matrix_i.release_key(3, 7);
        wait_cycles(4);
        @(posedge core_clk);
        kbms_key_matrix_i.press(3, 7);
        wait_cycles(4);
        check(int_req_n, 12'h001);
        // all-of, active-high watch on bit 0 only
        io_write(KBMS_ADDR_INPUT_CTRL, 8'hF7);
        io_write(KBMS_ADDR_INPUT_CTRL, 8'hFE);
        wait_cycles(3);
        check(int_req_n, 12'h001);
        @(posedge core_clk);
        kbms_key_matrix_i.release_key(3, 0);
        wait_cycles(4);
        check(int_req_n, 12'h000);
        pulse(0);
        check(int_vector, 12'h070);
        pulse(1);
        report_and_stop();
    end
endmodule : kbms_scan_test
